// ### src/rnic_top.sv
// Functional notes
// - power-on reset clears whole status word
// - watchdog starts running in watchdog mode
// - reset end loads counter from reset vector
// - pin powers up in reset function
// - pin function chosen by watchdog control field
// - pin low holds reset, high starts execution
// - fixed chain priority, nearer cpu wins
// - nmi ignores global enable, uses own enables
// - nmi acceptance clears all three nmi enables
// - accepted nmi vectors through shared nmi word
// - pin edge, osc fault, flash violation combine
// - selected edge sets flag, requests if enabled
// - power-up clear returns pin to reset
// - edge select change may trigger nmi only in nmi mode
// - flash violation flag, request only when enabled
// - osc fault flag, request only when enabled
// - power-up clear forces oscillators to safe state
// - nmi source flags survive acceptance
// - per-source enables and global enable gate maskables
// - interval-mode watchdog overflow is maskable interrupt
// - maskable needs both enables, nmi only own
// - single-source flag clears on acceptance
// - six cycles from acceptance to first instruction
`timescale 1ns/1ps
`default_nettype none
`include "rnic_defines.svh"

module rnic_top
  import rnic_pkg::*;
#(
  parameter int NPER = 14
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        rst_nmi_pin,
  input  wire logic        osc_fault_in,
  input  wire logic        flash_viol_in,
  input  wire logic        wdt_overflow,
  input  wire logic        wdt_key_viol,
  input  wire logic        flash_key_viol,
  input  wire logic        wdt_ctl_wr,
  input  wire logic [15:0] wdt_ctl_wdata,
  input  wire logic        psw_wr,
  input  wire logic [15:0] psw_wdata,
  input  wire logic        nmi_ie_wr,
  input  wire logic [2:0]  nmi_ie_wdata,
  input  wire logic [2:0]  nmi_flag_clr,
  input  wire logic        wdt_irq_enable,
  input  wire logic        wdt_flag_clr,
  input  wire logic [NPER-1:0] periph_irq,
  input  wire logic [NPER-1:0] periph_ie,
  input  wire logic        irq_accept,
  input  wire logic [15:0] vec_rdata,
  output var  logic        cpu_reset_q,
  output var  logic        puc_q,
  output var  logic        osc_safe_q,
  output var  logic [15:0] psw_q,
  output var  logic [15:0] wdt_ctl_q,
  output var  logic [2:0]  nmi_ie_q,
  output var  logic [2:0]  nmi_flags_q,
  output var  logic        wdt_flag_q,
  output var  logic        irq_pending_q,
  output var  logic [15:0] irq_ack_q,
  output var  logic        vec_rd_q,
  output var  logic [15:0] vec_addr_q,
  output var  logic        pc_load_q,
  output var  logic [15:0] pc_value_q
);

  rnic_state_type  state_q;
  rnic_state_type  state_d;
  logic [2:0]      cnt_q;
  logic [3:0]      slot_q;
  logic            act_prev_q;
  logic [NPER-1:0] periph_q;
  logic            flash_viol_q;
  logic            wdt_ovf_q;

  // pin and oscillator fault come from outside the clock domain
  logic [1:0] async_s;
  logic       pin_s;
  logic       osc_s;

  rnic_sync #(
    .W (2)
  ) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({osc_fault_in, rst_nmi_pin}),
    .sync_out (async_s)
  );

  assign pin_s = async_s[0];
  assign osc_s = async_s[1];

  // same-domain interrupt sources get one register stage
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      periph_q     <= '0;
      flash_viol_q <= 1'b0;
      wdt_ovf_q    <= 1'b0;
    end else begin
      periph_q     <= periph_irq;
      flash_viol_q <= flash_viol_in;
      wdt_ovf_q    <= wdt_overflow;
    end
  end

  // pin function and watchdog mode decode
  logic nmi_mode;
  logic nmi_es;
  logic wdt_interval;

  assign nmi_mode     = wdt_ctl_q[`RNIC_WDC_NMI];
  assign nmi_es       = wdt_ctl_q[`RNIC_WDC_NMI_EDGE_SELECT];
  assign wdt_interval = wdt_ctl_q[`RNIC_WDC_TMSEL];

  // reset and power-up clear sources
  logic pin_reset;
  logic wdt_expire;
  logic puc_evt;

  assign pin_reset  = !nmi_mode && !pin_s;
  assign wdt_expire = wdt_ovf_q && !wdt_interval;
  assign puc_evt    = pin_reset || wdt_expire || wdt_key_viol || flash_key_viol;

  // pin edge detect: active level follows the select bit
  logic pin_active;
  logic pin_edge;

  assign pin_active = nmi_es ? !pin_s : pin_s;
  assign pin_edge   = nmi_mode && pin_active && !act_prev_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      act_prev_q <= 1'b0;
    end else begin
      act_prev_q <= pin_active; // tracks outside nmi mode too
    end
  end

  rnic_prio_if prio (); // chain carrier, declared ahead of the decode that reads it

  // acceptance decode
  logic accept;
  logic acc_nmi;
  logic acc_wdt;

  assign accept  = irq_accept && irq_pending_q && (state_q == ST_RUN);
  assign acc_nmi = accept && (prio.idx == `RNIC_SLOT_NMI);
  assign acc_wdt = accept && (prio.idx == `RNIC_SLOT_WDT) && wdt_flag_q;

  // watchdog control: puc returns pin to reset function
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_ctl_q <= `RNIC_WDC_RST;
    end else if (puc_evt) begin
      wdt_ctl_q <= `RNIC_WDC_RST;
    end else if (wdt_ctl_wr) begin
      wdt_ctl_q <= wdt_ctl_wdata;
    end
  end

  // status word: cleared on reset and on acceptance except scg0
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      psw_q <= `RNIC_PSW_RST;
    end else if (puc_evt) begin
      psw_q <= `RNIC_PSW_RST;
    end else if (accept) begin
      psw_q <= psw_q & (16'h0001 << `RNIC_PSW_SCG0);
    end else if (psw_wr) begin
      psw_q <= psw_wdata;
    end
  end

  // nmi enables: nmi acceptance clears all three
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_ie_q <= 3'h0;
    end else if (puc_evt || acc_nmi) begin
      nmi_ie_q <= 3'h0;
    end else if (nmi_ie_wr) begin
      nmi_ie_q <= nmi_ie_wdata;
    end
  end

  // nmi source flags: set wins over clear, kept on acceptance
  logic [2:0] flag_set;

  assign flag_set[`RNIC_NMI_PIN]   = pin_edge;
  assign flag_set[`RNIC_NMI_OSC]   = osc_s;
  assign flag_set[`RNIC_NMI_FLASH] = flash_viol_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_flags_q <= 3'h0;
    end else begin
      nmi_flags_q <= flag_set | (nmi_flags_q & ~nmi_flag_clr);
      if (puc_evt) begin
        nmi_flags_q[`RNIC_NMI_PIN]   <= 1'b0;
        nmi_flags_q[`RNIC_NMI_FLASH] <= flash_viol_q;
      end
    end
  end

  // watchdog interval flag: single source, cleared on acceptance
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_flag_q <= 1'b0;
    end else if (wdt_ovf_q && wdt_interval) begin
      wdt_flag_q <= 1'b1;
    end else if (acc_wdt || wdt_flag_clr || puc_evt) begin
      wdt_flag_q <= 1'b0;
    end
  end

  // request vector for the chain
  logic       global_irq_enable;
  logic       nmi_req;
  logic [15:0] mask_req;

  assign global_irq_enable     = psw_q[`RNIC_PSW_GIE];
  assign nmi_req = |(nmi_flags_q & nmi_ie_q);

  always_comb begin
    mask_req = '0;
    mask_req[NPER-1:0] = periph_q & periph_ie;
    mask_req[`RNIC_SLOT_WDT] = mask_req[`RNIC_SLOT_WDT] ||
                               (wdt_flag_q && wdt_irq_enable);
    mask_req[`RNIC_SLOT_NMI] = 1'b0;
    mask_req[`RNIC_SLOT_RESET] = 1'b0;
  end

  assign prio.req = (global_irq_enable ? mask_req : 16'h0000) |
                    ({15'h0000, nmi_req} << `RNIC_SLOT_NMI);

  rnic_prio u_prio (
    .bus (prio.arb)
  );

  // vector word of the winning slot
  logic [15:0] slot_vec;

  assign slot_vec = `RNIC_VEC_BASE | {11'h000, slot_q, 1'b0};

  // sequencer: hold in reset, then six-cycle vector load
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_HOLD: begin
        if (!puc_evt) begin
          state_d = ST_LATENCY;
        end
      end
      ST_LATENCY: begin
        if (puc_evt) begin
          state_d = ST_HOLD;
        end else if (cnt_q == `RNIC_LAT_CYC - 3'd1) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (puc_evt) begin
          state_d = ST_HOLD;
        end else if (accept) begin
          state_d = ST_LATENCY;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // latency counter and captured slot
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= 3'h0;
      slot_q <= `RNIC_SLOT_RESET;
    end else if (state_d == ST_HOLD) begin
      cnt_q  <= 3'h0;
      slot_q <= `RNIC_SLOT_RESET;
    end else if (state_q != ST_LATENCY) begin
      cnt_q  <= 3'h1;
      if (accept) begin
        slot_q <= prio.idx;
      end
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // vector read in cycle 4, program counter load in cycle 6
  logic rd_cyc;
  logic ld_cyc;

  assign rd_cyc = (state_q == ST_LATENCY) && (cnt_q == `RNIC_LAT_CYC - 3'd3);
  assign ld_cyc = (state_q == ST_LATENCY) && (cnt_q == `RNIC_LAT_CYC - 3'd1) &&
                  !puc_evt;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vec_rd_q   <= 1'b0;
      vec_addr_q <= `RNIC_VEC_RESET;
      pc_load_q  <= 1'b0;
      pc_value_q <= 16'h0000;
    end else begin
      vec_rd_q  <= rd_cyc && !puc_evt;
      pc_load_q <= ld_cyc;
      if (rd_cyc) begin
        vec_addr_q <= slot_vec;
      end
      if (ld_cyc) begin
        pc_value_q <= vec_rdata;
      end
    end
  end

  // acceptance pulse to single-source peripherals
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ack_q <= 16'h0000;
    end else if (accept && (prio.idx != `RNIC_SLOT_NMI)) begin
      irq_ack_q <= 16'h0001 << prio.idx;
    end else begin
      irq_ack_q <= 16'h0000;
    end
  end

  // request to cpu, only while running
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pending_q <= 1'b0;
    end else begin
      irq_pending_q <= prio.any && (state_d == ST_RUN) && !accept;
    end
  end

  // reset outputs: puc forces oscillators safe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_reset_q <= 1'b1;
      puc_q       <= 1'b1;
      osc_safe_q  <= 1'b1;
    end else begin
      cpu_reset_q <= (state_d == ST_HOLD);
      puc_q       <= puc_evt;
      osc_safe_q  <= puc_evt;
    end
  end

endmodule

`default_nettype wire

// ### src/rnic_defines.svh
`ifndef RNIC_DEFINES_SVH
`define RNIC_DEFINES_SVH

// vector words
`define RNIC_VEC_RESET    16'hFFFE
`define RNIC_VEC_NMI      16'hFFFC
`define RNIC_VEC_BASE     16'hFFE0

// priority slots in the chain
`define RNIC_SLOT_RESET   4'd15
`define RNIC_SLOT_NMI     4'd14
`define RNIC_SLOT_WDT     4'd10

// status word fields
`define RNIC_PSW_GIE      3
`define RNIC_PSW_SCG0     6
`define RNIC_PSW_RST      16'h0000

// watchdog control fields
`define RNIC_WDC_TMSEL    4
`define RNIC_WDC_NMI      5
`define RNIC_WDC_NMI_EDGE_SELECT    6
`define RNIC_WDC_RST      16'h0000

// non-maskable source bit positions
`define RNIC_NMI_PIN      0
`define RNIC_NMI_OSC      1
`define RNIC_NMI_FLASH    2

// acceptance latency in mclk cycles
`define RNIC_LAT_CYC      3'd6

`endif

// ### src/rnic_pkg.sv
package rnic_pkg;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_LATENCY,
    ST_RUN
  } rnic_state_type;

  typedef logic [15:0] rnic_word_type;

endpackage

// ### src/rnic_prio_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rnic_prio_if;
  logic [15:0] req;
  logic        any;
  logic [3:0]  idx;
  modport arb  (input req, output any, output idx);
  modport user (output req, input any, input idx);
endinterface

`default_nettype wire

// ### src/rnic_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rnic_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // two flops per bit, first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### src/rnic_prio.sv
`timescale 1ns/1ps
`default_nettype none

module rnic_prio (
  rnic_prio_if.arb bus
);

  // daisy chain: higher slot sits nearer the cpu and wins
  always_comb begin
    bus.idx = 4'h0;
    bus.any = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (bus.req[i]) begin
        bus.idx = 4'(i);
        bus.any = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### verification/rnic_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

module rnic_top_chk #(
  parameter int NPER = 14
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        rst_nmi_pin,
  input wire logic        osc_fault_in,
  input wire logic        flash_viol_in,
  input wire logic [15:0] vec_rdata,
  input wire logic        cpu_reset_q,
  input wire logic        puc_q,
  input wire logic        osc_safe_q,
  input wire logic [15:0] psw_q,
  input wire logic [15:0] wdt_ctl_q,
  input wire logic [2:0]  nmi_ie_q,
  input wire logic [2:0]  nmi_flags_q,
  input wire logic        irq_pending_q,
  input wire logic        vec_rd_q,
  input wire logic [15:0] vec_addr_q,
  input wire logic        pc_load_q,
  input wire logic [15:0] pc_value_q
);
  logic nmi_req;

  // any enabled non-maskable source
  assign nmi_req = |(nmi_flags_q & nmi_ie_q);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  latency_six_a: assert property ($fell(irq_pending_q) |-> ##3 vec_rd_q ##2
    (pc_load_q && pc_value_q == $past(vec_rdata))) else $error("bad acceptance walk");
  reset_vec_a: assert property ($fell(cpu_reset_q) |-> ##3
    (vec_rd_q && vec_addr_q == 16'hfffe)) else $error("no reset vector read");
  nmi_accept_a: assert property ($fell(irq_pending_q) && $past(nmi_req) |->
    nmi_ie_q == 3'b000 ##3 vec_addr_q == 16'hfffc) else $error("bad nmi acceptance");
  gie_gate_a: assert property ($rose(irq_pending_q) |->
    $past(psw_q[3]) || $past(nmi_req)) else $error("request without enable");
  pin_hold_a: assert property ((!rst_nmi_pin && !wdt_ctl_q[5]) [*3] |->
    ##[1:3] cpu_reset_q) else $error("pin low not holding reset");
  pin_flag_a: assert property ($rose(nmi_flags_q[0]) |-> $past(wdt_ctl_q[5]))
    else $error("pin flag outside nmi mode");
  osc_flag_a: assert property (osc_fault_in [*3] |-> ##[1:3] nmi_flags_q[1])
    else $error("osc fault not flagged");
  flash_flag_a: assert property (flash_viol_in |-> ##[1:3] nmi_flags_q[2])
    else $error("flash violation not flagged");
  flags_keep_a: assert property ($fell(irq_pending_q) |->
    (nmi_flags_q & $past(nmi_flags_q)) == $past(nmi_flags_q)) else $error("flag lost");
  puc_clear_a: assert property (puc_q |-> psw_q == 16'h0000 && nmi_ie_q == 3'b000
    && osc_safe_q) else $error("power-up clear incomplete");
endmodule

bind rnic_top rnic_top_chk #(.NPER(NPER)) u_chk (
  .mclk, .reset_n, .rst_nmi_pin, .osc_fault_in, .flash_viol_in, .vec_rdata, .cpu_reset_q,
  .puc_q, .osc_safe_q, .psw_q, .wdt_ctl_q, .nmi_ie_q, .nmi_flags_q, .irq_pending_q,
  .vec_rd_q, .vec_addr_q, .pc_load_q, .pc_value_q
);

`default_nettype wire

// ### verification/rnic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module rnic_cpu_model (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  delay,
  input  wire logic        irq_pending_q,
  input  wire logic        vec_rd_q,
  input  wire logic [15:0] vec_addr_q,
  input  wire logic        pc_load_q,
  output var  logic        irq_accept,
  output var  logic [15:0] vec_rdata
);
  logic       busy_q;
  logic [3:0] wait_q;

  // accept after a programmable wait, one request per service
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_accept <= 1'b0;
      busy_q     <= 1'b0;
      wait_q     <= 4'h0;
    end else begin
      irq_accept <= irq_pending_q && !busy_q && !irq_accept && wait_q >= delay;
      wait_q     <= (irq_pending_q && !busy_q) ? wait_q + 4'h1 : 4'h0;
      busy_q     <= (busy_q || (irq_accept && irq_pending_q)) && !pc_load_q;
    end
  end

  // vector word in the cycle after the read, a moving pattern otherwise
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) vec_rdata <= 16'h0000;
    else vec_rdata <= vec_rd_q ? vec_addr_q ^ 16'h5a5a : ~vec_rdata;
  end
endmodule

`default_nettype wire

// ### verification/rnic_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rnic_top_tb;
  localparam int NPER = 14;
  logic            mclk, reset_n, rst_nmi_pin, osc_fault_in, flash_viol_in;
  logic            wdt_overflow, wdt_key_viol, wdt_ctl_wr, psw_wr, nmi_ie_wr, flash_key_viol;
  logic            wdt_irq_enable, irq_accept, cpu_reset_q, puc_q, osc_safe_q;
  logic            wdt_flag_q, irq_pending_q, vec_rd_q, pc_load_q;
  logic [2:0]      nmi_ie_wdata, nmi_flag_clr, nmi_ie_q, nmi_flags_q;
  logic [3:0]      cpu_delay;
  logic [15:0]     wdt_ctl_wdata, psw_wdata, vec_rdata, psw_q, wdt_ctl_q, irq_ack_q;
  logic [15:0]     vec_addr_q, pc_value_q, lfsr_q;
  logic [NPER-1:0] periph_irq, periph_ie;
  int              errors, checks_done;

  rnic_top #(.NPER(NPER)) u_dut (
    .mclk, .reset_n, .rst_nmi_pin, .osc_fault_in, .flash_viol_in, .wdt_overflow,
    .wdt_key_viol, .flash_key_viol, .wdt_ctl_wr, .wdt_ctl_wdata, .psw_wr, .psw_wdata,
    .nmi_ie_wr, .nmi_ie_wdata, .nmi_flag_clr, .wdt_irq_enable, .wdt_flag_clr(1'b0),
    .periph_irq, .periph_ie, .irq_accept, .vec_rdata, .cpu_reset_q, .puc_q, .osc_safe_q,
    .psw_q, .wdt_ctl_q, .nmi_ie_q, .nmi_flags_q, .wdt_flag_q, .irq_pending_q, .irq_ack_q,
    .vec_rd_q, .vec_addr_q, .pc_load_q, .pc_value_q
  );

  rnic_cpu_model u_cpu (
    .mclk, .reset_n, .delay(cpu_delay), .irq_pending_q, .vec_rd_q, .vec_addr_q, .pc_load_q,
    .irq_accept, .vec_rdata
  );

  // 40 MHz system clock
  always #12.5 mclk = ~mclk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction

  // reference: highest set slot of a request mask
  function automatic int top_slot(input logic [13:0] m);
    int s;
    s = -1;
    for (int k = 0; k < 14; k++) begin
      if (m[k]) s = k;
    end
    return s;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one-cycle strobe: 0 watchdog control, 1 status word, 2 nmi enables
  task automatic wr(input int which, input logic [15:0] d);
    @(posedge mclk);
    wdt_ctl_wr    <= which == 0;
    psw_wr        <= which == 1;
    nmi_ie_wr     <= which == 2;
    wdt_ctl_wdata <= d;
    psw_wdata     <= d;
    nmi_ie_wdata  <= d[2:0];
    @(posedge mclk);
    {wdt_ctl_wr, psw_wr, nmi_ie_wr} <= 3'b000;
  endtask

  task automatic clr_flags();
    @(posedge mclk);
    nmi_flag_clr <= 3'b111;
    @(posedge mclk);
    nmi_flag_clr <= 3'b000;
  endtask

  // wait for the vector read, then check address, load and loaded value
  task automatic service(input int slot);
    int          n;
    logic [15:0] va;
    logic [15:0] ack;
    n = 0;
    va = 16'hffe0 + 16'(2 * slot);
    ack = 16'h0000;
    do begin
      @(negedge mclk);
      ack = ack | irq_ack_q;
      n++;
    end while (vec_rd_q !== 1'b1 && n < 80);
    check(16'(n < 80), 16'h0001);
    if (n >= 80) end_of_test();
    check(vec_addr_q, va);
    check(ack, (slot < 14) ? (16'h0001 << slot) : 16'h0000);
    repeat (2) @(negedge mclk);
    check(16'(pc_load_q), 16'h0001);
    check(pc_value_q, va ^ 16'h5a5a);
  endtask

  initial begin
    logic [13:0] m;
    mclk = 1'b0;
    reset_n = 1'b0;
    {rst_nmi_pin, osc_fault_in, flash_viol_in, wdt_overflow, wdt_key_viol, flash_key_viol} = 6'h00;
    {wdt_ctl_wr, psw_wr, nmi_ie_wr, wdt_irq_enable} = 4'h0;
    {wdt_ctl_wdata, psw_wdata} = 32'h0000_0000;
    {nmi_ie_wdata, nmi_flag_clr} = 6'h00;
    {periph_irq, periph_ie} = 28'h000_0000;
    cpu_delay = 4'h0;
    errors = 0;
    checks_done = 0;
    lfsr_q = 16'h004b;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    // pin low holds the cpu; power-on values; pin high starts from the reset vector
    repeat (6) @(negedge mclk);
    check(16'(cpu_reset_q), 16'h0001);
    check(psw_q, 16'h0000);
    check(wdt_ctl_q, 16'h0000);
    @(posedge mclk);
    rst_nmi_pin <= 1'b1;
    service(15);
    $display("test reset done");
    // random requests and enables, masked while global enable is off
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr(lfsr_q);
      m = (lfsr_q[13:0] | 14'h0001) & (lfsr_q[15:2] | 14'h0001);
      @(posedge mclk);
      periph_irq <= lfsr_q[13:0] | 14'h0001;
      periph_ie  <= lfsr_q[15:2] | 14'h0001;
      cpu_delay  <= 4'(i % 3);
      repeat (5) @(negedge mclk);
      check(16'(irq_pending_q), 16'h0000);
      wr(1, 16'h0008);
      service(top_slot(m));
      @(negedge mclk);
      check(psw_q, 16'h0000);
      @(posedge mclk);
      periph_irq <= 14'h0000;
    end
    $display("test priority done");
    // falling pin edge in nmi mode, global enable off
    wr(0, 16'h0060);
    wr(2, 16'h0001);
    @(posedge mclk);
    rst_nmi_pin <= 1'b0;
    service(14);
    check(16'(nmi_ie_q), 16'h0000);
    check(16'(nmi_flags_q), 16'h0001);
    @(posedge mclk);
    rst_nmi_pin <= 1'b1;
    clr_flags();
    wr(0, 16'h0020);
    repeat (6) @(negedge mclk);
    check(16'(nmi_flags_q), 16'h0001);
    check(16'(irq_pending_q), 16'h0000);
    clr_flags();
    wr(0, 16'h0000);
    wr(0, 16'h0040);
    wr(0, 16'h0060);
    repeat (6) @(negedge mclk);
    check(16'(nmi_flags_q), 16'h0000);
    $display("test pin done");
    // oscillator fault and flash violation flag without enables
    @(posedge mclk);
    {osc_fault_in, flash_viol_in} <= 2'b11;
    @(posedge mclk);
    flash_viol_in <= 1'b0;
    repeat (2) @(posedge mclk);
    osc_fault_in <= 1'b0;
    repeat (6) @(negedge mclk);
    check(16'(nmi_flags_q), 16'h0006);
    check(16'(irq_pending_q), 16'h0000);
    wr(2, 16'h0004);
    service(14);
    check(16'(nmi_flags_q), 16'h0006);
    clr_flags();
    $display("test sources done");
    // interval watchdog overflow, then a key violation with the pin low in nmi mode
    wr(0, 16'h0070);
    wr(1, 16'h0008);
    @(posedge mclk);
    {wdt_irq_enable, wdt_overflow} <= 2'b11;
    @(posedge mclk);
    wdt_overflow <= 1'b0;
    service(10);
    @(negedge mclk);
    check(16'(wdt_flag_q), 16'h0000);
    @(posedge mclk);
    rst_nmi_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    wdt_key_viol <= 1'b1;
    @(posedge mclk);
    wdt_key_viol <= 1'b0;
    repeat (8) @(negedge mclk);
    check(16'(cpu_reset_q), 16'h0001);
    check(wdt_ctl_q, 16'h0000);
    check(16'(osc_safe_q), 16'h0001);
    @(posedge mclk);
    rst_nmi_pin <= 1'b1;
    service(15);
    // flash key violation: one-cycle power-up clear with the pin high
    @(posedge mclk);
    flash_key_viol <= 1'b1;
    @(posedge mclk);
    flash_key_viol <= 1'b0;
    @(negedge mclk);
    check(16'(puc_q), 16'h0001);
    check(16'(osc_safe_q), 16'h0001);
    check(16'(cpu_reset_q), 16'h0001);
    service(15);
    $display("test clear done");
    end_of_test();
  end
endmodule

`default_nettype wire
